// [core/spi_select_out_bidir_pins.sv]
// Serial controller pin logic: automatic select output and single data pin mode
`timescale 1ns/1ps
module spi_select_out_bidir_pins
    import spi_pins_pkg::*;
(
    input  wire logic              I_MCLK,
    input  wire logic              I_RST,
    input  wire logic              I_MASTER_SELECT,
    input  wire logic              I_SELECT_OUTPUT_ENABLE,
    input  wire logic              I_FAULT_DETECT_ENABLE,
    input  wire logic              I_SINGLE_PIN_CONTROL,
    input  wire logic              I_BIDIR_OUT_ENABLE,
    input  wire logic [DIV_W-1:0]  I_DIV_HALF,
    input  wire logic              I_FAULT_CLEAR,
    input  wire logic              I_TX_VALID,
    output logic                   O_TX_READY,
    input  wire logic [DATA_W-1:0] I_TX_DATA,
    output logic                   O_RX_VALID,
    input  wire logic              I_RX_READY,
    output logic [DATA_W-1:0]      O_RX_DATA,
    input  wire logic              I_SCK,
    output logic                   O_SCK,
    output logic                   O_SCK_OE,
    input  wire logic              I_SS_N,
    output logic                   O_SS_N,
    output logic                   O_SS_N_OE,
    input  wire logic              I_MOSI,
    output logic                   O_MOSI,
    output logic                   O_MOSI_OE,
    input  wire logic              I_MISO,
    output logic                   O_MISO,
    output logic                   O_MISO_OE,
    output logic                   O_MODE_FAULT,
    output logic                   O_BUSY
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] sync1_reg, sync2_reg;
    logic [3:0] sync1_next;
    logic       sck_s, ss_s, mosi_s, miso_s;

    always_comb begin
        sync1_next = {I_SCK, I_SS_N, I_MOSI, I_MISO};
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync1_reg;
        end
    end

    assign {sck_s, ss_s, mosi_s, miso_s} = sync2_reg;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    logic auto_ss, fault_check, bidir;

    assign auto_ss     = I_MASTER_SELECT && I_SELECT_OUTPUT_ENABLE
                         && I_FAULT_DETECT_ENABLE;
    // Fault check only on a master input select; multi-master users lose this
    assign fault_check = I_MASTER_SELECT && I_FAULT_DETECT_ENABLE
                         && !I_SELECT_OUTPUT_ENABLE;
    assign bidir       = I_SINGLE_PIN_CONTROL;

    // ****************************************************************
    // Receive path buffer
    // ****************************************************************
    logic              rx_push_reg, rx_push_next;
    logic [DATA_W-1:0] rx_word_reg, rx_word_next;
    logic              buf_ready;

    spi_skid_buffer spi_skid_buffer_inst (
        .clk     (I_MCLK),
        .rst     (I_RST),
        .i_valid (rx_push_reg),
        .o_ready (buf_ready),
        .i_data  (rx_word_reg),
        .o_valid (O_RX_VALID),
        .i_ready (I_RX_READY),
        .o_data  (O_RX_DATA)
    );

    // ****************************************************************
    // Transfer engine
    // ****************************************************************
    xfer_state_type    st_reg, st_next;
    logic [DATA_W-1:0] sh_reg, sh_next;
    logic [CNT_W-1:0]  bit_reg, bit_next;
    logic [DIV_W-1:0]  div_reg, div_next;
    logic              sck_reg, sck_next;
    logic              sck_prev_reg, sck_prev_next;
    logic              fault_reg, fault_next;
    logic              ss_reg, ss_next;
    logic              in_bit_reg, in_bit_next;
    logic              din, slave_sel, tick, rise, fall;

    function automatic logic pick_in(input logic bi, input logic mst,
                                     input logic mo, input logic mi);
        // Unused pin never sampled in single pin mode
        if (bi) begin
            pick_in = mst ? mo : mi;
        end else begin
            pick_in = mst ? mi : mo;
        end
    endfunction : pick_in

    always_comb begin
        din           = pick_in(bidir, I_MASTER_SELECT, mosi_s, miso_s);
        slave_sel     = !I_MASTER_SELECT && !ss_s;
        st_next       = st_reg;
        sh_next       = sh_reg;
        bit_next      = bit_reg;
        div_next      = DIV_RST;
        sck_next      = 1'b0;
        sck_prev_next = sck_s;
        rx_push_next  = 1'b0;
        rx_word_next  = rx_word_reg;
        in_bit_next   = in_bit_reg;
        tick          = 1'b0;
        rise          = 1'b0;
        fall          = 1'b0;
        fault_next    = fault_reg;
        if (I_FAULT_CLEAR) begin
            fault_next = 1'b0;
        end
        // Set wins over clear so a late fault is kept
        if (fault_check && !ss_s) begin
            fault_next = 1'b1;
        end
        if (I_MASTER_SELECT && st_reg == ST_SHIFT) begin
            sck_next = sck_reg;
            if (div_reg >= I_DIV_HALF) begin
                tick     = 1'b1;
                sck_next = ~sck_reg;
            end else begin
                div_next = div_reg + 8'h01;
            end
            rise = tick && !sck_reg;
            fall = tick && sck_reg;
        end else if (!I_MASTER_SELECT) begin
            rise = sck_s && !sck_prev_reg && slave_sel;
            fall = !sck_s && sck_prev_reg && slave_sel;
        end
        unique case (st_reg)
            ST_IDLE: begin
                bit_next = CNT_RST;
                // A push in flight counts as full, else the word would wait in done
                if (I_MASTER_SELECT && I_TX_VALID && buf_ready && !rx_push_reg
                    && !fault_reg) begin
                    sh_next = I_TX_DATA;
                    st_next = ST_SHIFT;
                end else if (slave_sel && I_TX_VALID) begin
                    sh_next = I_TX_DATA;
                    st_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // Sample on rise, shift on fall: out bit never moves under a rising clock
                if (rise) begin
                    in_bit_next = din;
                end
                if (fall) begin
                    sh_next = {sh_reg[DATA_W-2:0], in_bit_reg};
                    if (bit_reg == BIT_LAST) begin
                        st_next = ST_DONE;
                    end else begin
                        bit_next = bit_reg + 4'h1;
                    end
                end
                if ((!I_MASTER_SELECT && ss_s) || fault_reg) begin
                    st_next = ST_IDLE;
                end
            end
            ST_DONE: begin
                rx_push_next = buf_ready;
                rx_word_next = sh_reg;
                if (buf_ready) begin
                    st_next = ST_IDLE;
                end
            end
        endcase
        // Select low through the whole transfer, high when idle
        ss_next = !(auto_ss && st_next != ST_IDLE);
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            st_reg       <= ST_IDLE;
            sh_reg       <= DATA_RST;
            bit_reg      <= CNT_RST;
            div_reg      <= DIV_RST;
            sck_reg      <= 1'b0;
            sck_prev_reg <= 1'b0;
            fault_reg    <= 1'b0;
            ss_reg       <= 1'b1;
            rx_push_reg  <= 1'b0;
            rx_word_reg  <= DATA_RST;
            in_bit_reg   <= 1'b0;
        end else begin
            st_reg       <= st_next;
            sh_reg       <= sh_next;
            bit_reg      <= bit_next;
            div_reg      <= div_next;
            sck_reg      <= sck_next;
            sck_prev_reg <= sck_prev_next;
            fault_reg    <= fault_next;
            ss_reg       <= ss_next;
            rx_push_reg  <= rx_push_next;
            rx_word_reg  <= rx_word_next;
            in_bit_reg   <= in_bit_next;
        end
    end

    // ****************************************************************
    // Pin drivers, all registered
    // ****************************************************************
    logic [9:0] pins_reg, pins_next;
    logic       run, dout;

    always_comb begin
        run           = (st_reg == ST_SHIFT);
        dout          = sh_reg[DATA_W-1];
        pins_next     = 10'h000;
        pins_next[9]  = I_MASTER_SELECT && sck_reg;
        pins_next[8]  = I_MASTER_SELECT;
        pins_next[7]  = ss_reg;
        pins_next[6]  = auto_ss;
        pins_next[5]  = dout;
        pins_next[3]  = dout;
        pins_next[1]  = (st_reg == ST_IDLE && !I_TX_VALID) || st_reg == ST_DONE;
        pins_next[0]  = run;
        if (bidir) begin
            // Shared pin driven only when the direction bit says so
            pins_next[4] = I_MASTER_SELECT && I_BIDIR_OUT_ENABLE;
            pins_next[2] = !I_MASTER_SELECT && I_BIDIR_OUT_ENABLE && slave_sel;
        end else begin
            pins_next[4] = I_MASTER_SELECT;
            pins_next[2] = slave_sel;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            pins_reg <= PINS_RST;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign O_SCK        = pins_reg[9];
    assign O_SCK_OE     = pins_reg[8];
    assign O_SS_N       = pins_reg[7];
    assign O_SS_N_OE    = pins_reg[6];
    assign O_MOSI       = pins_reg[5];
    assign O_MOSI_OE    = pins_reg[4];
    assign O_MISO       = pins_reg[3];
    assign O_MISO_OE    = pins_reg[2];
    assign O_TX_READY   = pins_reg[1];
    assign O_BUSY       = pins_reg[0];
    assign O_MODE_FAULT = fault_reg;
endmodule : spi_select_out_bidir_pins

// [core/spi_pins_pkg.sv]
// Package of constants and types for the serial pin control block
package spi_pins_pkg;
    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int DATA_W          = 8;
    localparam int CNT_W           = 4;
    localparam int DIV_W           = 8;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [DIV_W-1:0]  DIV_RST  = 8'h00;
    localparam logic [CNT_W-1:0]  BIT_LAST = 4'h7;
    localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
    // Pin idle levels: clock low, select high, so reset shows no false edge
    localparam logic [3:0]        SYNC_RST = 4'h7;
    localparam logic [9:0]        PINS_RST = 10'h080;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } xfer_state_type;
endpackage : spi_pins_pkg

// [core/spi_skid_buffer.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module spi_skid_buffer
    import spi_pins_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              i_valid,
    output logic                   o_ready,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_valid,
    input  wire logic              i_ready,
    output logic [DATA_W-1:0]      o_data
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [DATA_W-1:0] mem_reg [2];
    logic [DATA_W-1:0] mem_next [2];
    logic              wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0]        cnt_reg, cnt_next;
    logic              push, pop;

    always_comb begin
        push     = i_valid && (cnt_reg != 2'h2);
        pop      = i_ready && (cnt_reg != 2'h0);
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        if (push) begin
            mem_next[wr_reg] = i_data;
            wr_next          = ~wr_reg;
        end
        if (pop) begin
            rd_next = ~rd_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_reg[0] <= DATA_RST;
            mem_reg[1] <= DATA_RST;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_ready = (cnt_reg != 2'h2);
    assign o_valid = (cnt_reg != 2'h0);
    assign o_data  = mem_reg[rd_reg];
endmodule : spi_skid_buffer

// [test/spi_pins_sva.sv]
// Concurrent checks on the pin control block ports
`timescale 1ns/1ps
module spi_pins_sva (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_MASTER_SELECT,
    input wire logic I_SELECT_OUTPUT_ENABLE,
    input wire logic I_FAULT_DETECT_ENABLE,
    input wire logic I_SINGLE_PIN_CONTROL,
    input wire logic I_BIDIR_OUT_ENABLE,
    input wire logic I_FAULT_CLEAR,
    input wire logic I_SS_N,
    input wire logic O_SCK,
    input wire logic O_SS_N,
    input wire logic O_SS_N_OE,
    input wire logic O_MOSI_OE,
    input wire logic O_MISO_OE,
    input wire logic O_MODE_FAULT,
    input wire logic O_BUSY
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    logic auto_sel;
    logic fault_arm;
    assign auto_sel  = I_MASTER_SELECT & I_SELECT_OUTPUT_ENABLE & I_FAULT_DETECT_ENABLE;
    assign fault_arm = I_MASTER_SELECT & I_FAULT_DETECT_ENABLE & ~I_SELECT_OUTPUT_ENABLE;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    a_ss_busy: assert property (auto_sel && O_BUSY |-> !O_SS_N)
        else $error("select high during transfer");
    a_ss_release: assert property (auto_sel && $fell(O_BUSY) |-> ##[0:4] O_SS_N)
        else $error("select not released after transfer");
    a_ss_drive: assert property (auto_sel [*2] |-> O_SS_N_OE)
        else $error("select pin not driven");
    a_ss_slave: assert property (!I_MASTER_SELECT [*2] |-> !O_SS_N_OE)
        else $error("select driven as slave");
    a_no_fault: assert property (auto_sel [*2] |-> !$rose(O_MODE_FAULT))
        else $error("fault raised with auto select");
    a_fault_set: assert property ((fault_arm && !I_SS_N && !I_FAULT_CLEAR) [*4]
        |=> O_MODE_FAULT)
        else $error("fault not raised");
    a_fault_block: assert property (O_MODE_FAULT [*3] |-> !$rose(O_BUSY))
        else $error("transfer started under fault");
    a_miso_free: assert property ((I_SINGLE_PIN_CONTROL && I_MASTER_SELECT) [*2]
        |-> !O_MISO_OE)
        else $error("unused pin driven as master");
    a_mosi_free: assert property ((I_SINGLE_PIN_CONTROL && !I_MASTER_SELECT) [*2]
        |-> !O_MOSI_OE)
        else $error("unused pin driven as slave");
    a_shared_out: assert property (I_SINGLE_PIN_CONTROL && I_MASTER_SELECT && I_BIDIR_OUT_ENABLE
        && O_BUSY && $past(O_BUSY) |-> O_MOSI_OE)
        else $error("shared pin not driven");
    a_sck_still: assert property (!O_BUSY [*3] |-> $stable(O_SCK))
        else $error("clock moves while idle");
endmodule : spi_pins_sva

bind spi_select_out_bidir_pins spi_pins_sva spi_pins_sva_inst (
    .I_MCLK, .I_RST, .I_MASTER_SELECT, .I_SELECT_OUTPUT_ENABLE, .I_FAULT_DETECT_ENABLE,
    .I_SINGLE_PIN_CONTROL, .I_BIDIR_OUT_ENABLE, .I_FAULT_CLEAR, .I_SS_N, .O_SCK, .O_SS_N,
    .O_SS_N_OE, .O_MOSI_OE, .O_MISO_OE, .O_MODE_FAULT, .O_BUSY);

// [test/spi_far_slave.sv]
// Far side serial slave model, mode 0, most significant bit first
`timescale 1ns/1ps
module spi_far_slave
    import spi_pins_pkg::*;
(
    input  wire logic              i_sck,
    input  wire logic              i_ss_n,
    input  wire logic              i_mosi,
    input  wire logic [DATA_W-1:0] i_reply,
    output logic                   o_miso,
    output logic [DATA_W-1:0]      o_got
);
    logic [DATA_W-1:0] shift_reg = DATA_RST;
    logic              last_reg  = 1'b0;
    initial o_got = DATA_RST;
    always @(negedge i_ss_n) shift_reg <= i_reply;
    always @(posedge i_sck) if (!i_ss_n) o_got <= {o_got[DATA_W-2:0], i_mosi};
    always @(negedge i_sck) if (!i_ss_n) begin
        last_reg  <= shift_reg[DATA_W-1];
        shift_reg <= shift_reg << 1;
    end
    // Deselected line shows the inverse, so a held stale bit cannot pass
    assign o_miso = i_ss_n ? ~last_reg : shift_reg[DATA_W-1];
endmodule : spi_far_slave

// [test/spi_select_out_bidir_pins_bench.sv]
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module spi_select_out_bidir_pins_bench;
    import spi_pins_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, master_sel = 1'b1, sel_oe = 1'b1, fault_en = 1'b1;
    logic single_pin = 1'b0, bidir_oe = 1'b0, fault_clr = 1'b0, tx_valid = 1'b0;
    logic rx_ready = 1'b0, ss_drv = 1'b1, m_sck = 1'b0;
    logic [7:0] tx_data = 8'h00, reply = 8'h00, rx_data, got;
    logic tx_ready, rx_valid, sck, sck_oe, ss_o, ss_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic fault, busy, p_miso, sck_w, ss_w, mosi_w, miso_w;
    int   err_total = 0, n_checks = 0;
    always #2.5 mclk = ~mclk;
    // Select is open drain with pull-up; ss_drv plays a second master
    assign ss_w   = (ss_oe ? ss_o : 1'b1) & ss_drv;
    assign sck_w  = sck_oe ? sck : m_sck;
    assign mosi_w = mosi_oe ? mosi_o : p_miso;
    assign miso_w = miso_oe ? miso_o : (single_pin ? ~p_miso : p_miso);
    spi_select_out_bidir_pins spi_select_out_bidir_pins_inst (
        .I_MCLK(mclk), .I_RST(rst), .I_MASTER_SELECT(master_sel), .I_SELECT_OUTPUT_ENABLE(sel_oe),
        .I_FAULT_DETECT_ENABLE(fault_en), .I_SINGLE_PIN_CONTROL(single_pin),
        .I_BIDIR_OUT_ENABLE(bidir_oe), .I_DIV_HALF(8'h03), .I_FAULT_CLEAR(fault_clr),
        .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .I_TX_DATA(tx_data),
        .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_RX_DATA(rx_data), .I_SCK(sck_w),
        .O_SCK(sck), .O_SCK_OE(sck_oe), .I_SS_N(ss_w), .O_SS_N(ss_o), .O_SS_N_OE(ss_oe),
        .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe), .I_MISO(miso_w),
        .O_MISO(miso_o), .O_MISO_OE(miso_oe), .O_MODE_FAULT(fault), .O_BUSY(busy));
    spi_far_slave spi_far_slave_inst (.i_sck(sck_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
        .i_reply(reply), .o_miso(p_miso), .o_got(got));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : chk
    task automatic pop_word(input logic [7:0] exp, input bit cmp);
        for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) @(negedge mclk);
        if (cmp) chk("rx word", exp, rx_data);
        rx_ready = 1'b1;
        @(negedge mclk);
        rx_ready = 1'b0;
        @(negedge mclk);
    endtask : pop_word
    task automatic send(input logic [7:0] tx, input logic [7:0] rp, input bit pop, input bit cmp);
        reply = rp;
        for (int i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge mclk);
        tx_data  = tx;
        tx_valid = 1'b1;
        for (int i = 0; i < 400 && busy !== 1'b1; i++) @(negedge mclk);
        tx_valid = 1'b0;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk);
        if (pop) pop_word(rp, cmp);
    endtask : send
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_auto();
        @(negedge mclk);
        send(8'hA5, 8'h3C, 1'b1, 1'b1);
        chk("far side word", 8'hA5, got);
        $display("test auto select done");
    endtask : t_auto
    task automatic t_fault();
        bit rose;
        @(negedge mclk);
        sel_oe = 1'b0;
        ss_drv = 1'b0;
        repeat (6) @(negedge mclk);
        chk("fault set", 8'h01, {7'h00, fault});
        rose = 1'b0;
        tx_valid = 1'b1;
        repeat (30) begin
            @(negedge mclk);
            if (busy !== 1'b0) rose = 1'b1;
        end
        tx_valid = 1'b0;
        chk("start blocked", 8'h00, {7'h00, rose});
        ss_drv = 1'b1;
        // Let the released select pass the synchroniser, else set beats clear
        repeat (3) @(negedge mclk);
        fault_clr = 1'b1;
        @(negedge mclk);
        fault_clr = 1'b0;
        sel_oe = 1'b1;
        repeat (2) @(negedge mclk);
        chk("fault cleared", 8'h00, {7'h00, fault});
        // A rival master goes unseen here, hence the caution for such systems
        ss_drv = 1'b0;
        repeat (8) @(negedge mclk);
        chk("no fault auto", 8'h00, {7'h00, fault});
        ss_drv = 1'b1;
        repeat (4) @(negedge mclk);
        $display("test mode fault done");
    endtask : t_fault
    task automatic t_bidir();
        @(negedge mclk);
        single_pin = 1'b1;
        send(8'h0F, 8'h5A, 1'b1, 1'b1);
        chk("miso enable", 8'h00, {7'h00, miso_oe});
        bidir_oe = 1'b1;
        send(8'hC3, 8'h00, 1'b1, 1'b0);
        chk("shared out word", 8'hC3, got);
        single_pin = 1'b0;
        bidir_oe = 1'b0;
        $display("test single pin done");
    endtask : t_bidir
    task automatic t_slave();
        logic [7:0] seen;
        @(negedge mclk);
        master_sel = 1'b0;
        single_pin = 1'b1;
        repeat (4) @(negedge mclk);
        chk("mosi enable", 8'h00, {7'h00, mosi_oe});
        chk("select enable", 8'h00, {7'h00, ss_oe});
        // Slave sending on its shared pin; bench plays clock and select
        seen = 8'h00;
        bidir_oe = 1'b1;
        ss_drv = 1'b0;
        tx_data = 8'h96;
        tx_valid = 1'b1;
        for (int i = 0; i < 400 && busy !== 1'b1; i++) @(negedge mclk);
        tx_valid = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (8) @(negedge mclk);
            m_sck = 1'b1;
            seen[i] = miso_w;
            repeat (8) @(negedge mclk);
            m_sck = 1'b0;
        end
        repeat (8) @(negedge mclk);
        chk("shared pin drive", 8'h01, {7'h00, miso_oe});
        chk("slave mosi enable", 8'h00, {7'h00, mosi_oe});
        chk("slave out word", 8'h96, seen);
        pop_word(8'h96, 1'b1);
        ss_drv = 1'b1;
        bidir_oe = 1'b0;
        master_sel = 1'b1;
        single_pin = 1'b0;
        repeat (4) @(negedge mclk);
        $display("test slave pins done");
    endtask : t_slave
    task automatic t_buffer();
        bit rose;
        @(negedge mclk);
        send(8'h11, 8'h21, 1'b0, 1'b0);
        send(8'h12, 8'h22, 1'b0, 1'b0);
        rose = 1'b0;
        tx_valid = 1'b1;
        repeat (40) begin
            @(negedge mclk);
            if (busy !== 1'b0) rose = 1'b1;
        end
        tx_valid = 1'b0;
        chk("full buffer stall", 8'h00, {7'h00, rose});
        pop_word(8'h21, 1'b1);
        pop_word(8'h22, 1'b1);
        $display("test buffer done");
    endtask : t_buffer
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        t_auto();
        t_fault();
        t_bidir();
        t_slave();
        t_buffer();
        conclude();
    end
endmodule : spi_select_out_bidir_pins_bench
